// ### gosfr_pkg.sv
package gosfr_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] SECONDARY_STATUS_ADDR = 8'h40;
	localparam logic [7:0] SECONDARY_FAULT_LATCH_ADDR = 8'h41;
	localparam logic [7:0] PIN_THREE_CONTROL_ADDR = 8'h42;
	localparam logic [7:0] DATA_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// secondary status bit positions
	// ----------------------------------------------------------------
	localparam int unsigned STAT_PIN_ONE = 6;
	localparam int unsigned STAT_PIN_TWO = 5;
	localparam int unsigned STAT_PIN_THREE = 4;
	localparam int unsigned STAT_ADC_BUSY = 3;
	localparam int unsigned STAT_ENERGY_OVF = 2;
	localparam int unsigned STAT_CHARGE_OVF = 1;
	localparam int unsigned STAT_TIME_OVF = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ----------------------------------------------------------------
	// secondary fault bit positions and reset value
	// ----------------------------------------------------------------
	localparam int unsigned FAULT_RSVD = 7;
	localparam int unsigned FAULT_PIN_ONE = 6;
	localparam int unsigned FAULT_PIN_TWO = 5;
	localparam int unsigned FAULT_PIN_THREE = 4;
	localparam int unsigned FAULT_WAKE = 3;
	localparam int unsigned FAULT_ENERGY = 2;
	localparam int unsigned FAULT_CHARGE = 1;
	localparam int unsigned FAULT_TIME = 0;
	localparam int unsigned FAULT_CELLS = 7;
	localparam logic FAULT_RSVD_VAL = 1'b1;
	localparam logic FAULT_CELL_RESET = 1'b0;

	// ----------------------------------------------------------------
	// pin three control bits
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_ALERT_GEN = 7;
	localparam int unsigned CTRL_PULL_DOWN = 6;
	localparam logic [5:0] CTRL_RSVD_VAL = 6'h00;
	localparam logic CTRL_BIT_RESET = 1'b0;

	// ----------------------------------------------------------------
	// pin configuration field positions and mode codes
	// ----------------------------------------------------------------
	localparam int unsigned CFG_PIN_ONE_LSB = 6;
	localparam int unsigned CFG_PIN_TWO_LSB = 4;
	localparam int unsigned CFG_PIN_THREE_LSB = 2;

	typedef enum logic [1:0] {
		PIN_MODE_SPECIAL = 2'h0,	// acc input (pin two) or alert output (pin three)
		PIN_MODE_OUTPUT = 2'h1,
		PIN_MODE_IN_LOW = 2'h2,
		PIN_MODE_IN_HIGH = 2'h3
	} gosfr_pin_mode_t;

endpackage

// ### gosfr_pin_decode.sv
module gosfr_pin_decode #(
	parameter bit HAS_ACC = 1'b0	// code 00 reports the raw level
) (
	input wire logic [1:0] mode,	// pin configuration field
	input wire logic pin_level,	// pin level, synchronous
	output logic state,	// state flag value
	output logic active	// input at its active level
);

	// ----------------------------------------------------------------
	// polarity adjustment
	// ----------------------------------------------------------------
	wire logic in_low = (mode == gosfr_pkg::PIN_MODE_IN_LOW);
	wire logic in_high = (mode == gosfr_pkg::PIN_MODE_IN_HIGH);
	wire logic in_acc = HAS_ACC && (mode == gosfr_pkg::PIN_MODE_SPECIAL);

	// output modes read back as zero
	assign active = (in_low & ~pin_level) | (in_high & pin_level);
	assign state = active | (in_acc & pin_level);

endmodule

// ### gosfr_fault_bit.sv
module gosfr_fault_bit #(
	parameter bit RESET_VAL = 1'b0	// value after reset
) (
	input wire logic core_clk,	// system clock
	input wire logic rst,	// synchronous reset, active high
	input wire logic set_in,	// hardware set condition
	input wire logic wr_en,	// host writes this register
	input wire logic wr_bit,	// written value of this bit
	output logic q_ff	// latched fault
);

	// ----------------------------------------------------------------
	// sticky latch
	// ----------------------------------------------------------------
	// write 0 clears
	// set beats a same-cycle clear so no event is lost
	wire logic nxt_q = set_in | (q_ff & ~(wr_en & ~wr_bit));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q_ff <= RESET_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end

	property p_set_wins;
		@(posedge core_clk) disable iff (rst) set_in |=> q_ff;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("fault set lost");

endmodule

// ### gosfr_regs.sv
// Notes on behaviour
// - pin one state follows active-polarity input
// - pin two reports acc level or activity
// - pin three state follows active-polarity input
// - flag shows converter busy in snapshot
// - energy overflow status is live
// - charge overflow status is live
// - time counter overflow status is live
// - pin faults latch at active input level
// - stuck-bus wake sets fault when enabled
// - energy overflow latches a fault
// - charge overflow latches a fault
// - time counter overflow latches a fault
// - alert output pulls low while generated
// - alert bit set by alert or write
// - host writes 0 to clear alert
// - alert bit ignored unless alert output
// - pull-down bit drives pin as output
// - pull-down bit ignored in other modes
// - code 00 alert, 01 general output
// - pin two code 00 is acc input
module gosfr_regs (
	input wire logic core_clk,	// system clock, 100 MHz
	input wire logic rst,	// synchronous reset, active high
	input wire logic [7:0] reg_addr,	// register offset
	input wire logic reg_wr,	// write strobe, one cycle
	input wire logic reg_rd,	// read strobe, one cycle
	input wire logic [7:0] reg_wdata,	// write data
	output logic [7:0] reg_rdata_ff,	// read data, cycle after strobe
	input wire logic [7:0] pin_config_field,	// pin configuration register
	input wire logic pin_one_in,	// pin one level
	input wire logic pin_two_in,	// pin two level
	input wire logic pin_three_in,	// pin three level
	input wire logic adc_snapshot_busy,	// converter busy in snapshot mode
	input wire logic energy_overflow,	// energy accumulator overflowed
	input wire logic charge_overflow,	// charge accumulator overflowed
	input wire logic time_overflow,	// time counter overflowed
	input wire logic stuck_bus_wake_enable,	// stuck-bus wake enable
	input wire logic stuck_bus_wake_evt,	// left shutdown on timer, pulse
	input wire logic alert_evt,	// alert raised, pulse
	output logic pin_three_out_ff,	// pin three output level, always low
	output logic pin_three_oe_ff,	// pin three pull-down enable
	output logic alert_generated_ff	// alert generated bit
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic sel_status = (reg_addr == gosfr_pkg::SECONDARY_STATUS_ADDR);
	wire logic sel_fault = (reg_addr == gosfr_pkg::SECONDARY_FAULT_LATCH_ADDR);
	wire logic sel_ctrl = (reg_addr == gosfr_pkg::PIN_THREE_CONTROL_ADDR);
	wire logic wr_fault = reg_wr & sel_fault;
	wire logic wr_ctrl = reg_wr & sel_ctrl;

	// configuration fields of the three pins
	wire logic [1:0] cfg_one = pin_config_field[gosfr_pkg::CFG_PIN_ONE_LSB +: 2];
	wire logic [1:0] cfg_two = pin_config_field[gosfr_pkg::CFG_PIN_TWO_LSB +: 2];
	wire logic [1:0] cfg_three = pin_config_field[gosfr_pkg::CFG_PIN_THREE_LSB +: 2];

	// ----------------------------------------------------------------
	// pin state decode
	// ----------------------------------------------------------------
	logic one_state;
	logic one_active;
	logic two_state;
	logic two_active;
	logic three_state;
	logic three_active;

	gosfr_pin_decode #(.HAS_ACC(1'b0)) u_dec_one (
		.mode(cfg_one),
		.pin_level(pin_one_in),
		.state(one_state),
		.active(one_active)
	);

	gosfr_pin_decode #(.HAS_ACC(1'b1)) u_dec_two (
		.mode(cfg_two),
		.pin_level(pin_two_in),
		.state(two_state),
		.active(two_active)
	);

	gosfr_pin_decode #(.HAS_ACC(1'b0)) u_dec_three (
		.mode(cfg_three),
		.pin_level(pin_three_in),
		.state(three_state),
		.active(three_active)
	);

	// ----------------------------------------------------------------
	// live status
	// ----------------------------------------------------------------
	// refreshed every cycle, reserved bit zero
	wire logic [7:0] nxt_status = {1'b0, one_state, two_state, three_state,
		adc_snapshot_busy, energy_overflow, charge_overflow, time_overflow};
	logic [7:0] status_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_ff <= gosfr_pkg::STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ----------------------------------------------------------------
	// latched faults
	// ----------------------------------------------------------------
	// set sources
	// overflow levels re-set a cleared fault while the overflow persists
	wire logic wake_fault = stuck_bus_wake_evt & stuck_bus_wake_enable;
	wire logic [6:0] fault_set = {one_active, two_active, three_active,
		wake_fault, energy_overflow, charge_overflow, time_overflow};
	logic [6:0] fault_q;

	genvar gi;
	generate
		for (gi = 0; gi < gosfr_pkg::FAULT_CELLS; gi++) begin : g_fault
			gosfr_fault_bit #(.RESET_VAL(gosfr_pkg::FAULT_CELL_RESET)) u_cell (
				.core_clk(core_clk),
				.rst(rst),
				.set_in(fault_set[gi]),
				.wr_en(wr_fault),
				.wr_bit(reg_wdata[gi]),
				.q_ff(fault_q[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin three control
	// ----------------------------------------------------------------
	// set wins over a same-cycle clear
	logic pull_down_ff;
	wire logic nxt_alert_gen = alert_evt |
		(wr_ctrl ? reg_wdata[gosfr_pkg::CTRL_ALERT_GEN] : alert_generated_ff);
	wire logic nxt_pull_down = wr_ctrl ? reg_wdata[gosfr_pkg::CTRL_PULL_DOWN] : pull_down_ff;

	wire logic nxt_oe =
		((cfg_three == gosfr_pkg::PIN_MODE_SPECIAL) & alert_generated_ff) |
		((cfg_three == gosfr_pkg::PIN_MODE_OUTPUT) & pull_down_ff);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			alert_generated_ff <= gosfr_pkg::CTRL_BIT_RESET;
			pull_down_ff <= gosfr_pkg::CTRL_BIT_RESET;
			pin_three_oe_ff <= 1'b0;
			pin_three_out_ff <= 1'b0;
		end else begin
			alert_generated_ff <= nxt_alert_gen;
			pull_down_ff <= nxt_pull_down;
			pin_three_oe_ff <= nxt_oe;
			pin_three_out_ff <= 1'b0;	// open drain: only ever pulls low
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// reserved control bits read zero
	wire logic [7:0] fault_word = {gosfr_pkg::FAULT_RSVD_VAL, fault_q};
	wire logic [7:0] ctrl_word = {alert_generated_ff, pull_down_ff, gosfr_pkg::CTRL_RSVD_VAL};
	wire logic [7:0] rd_mux = sel_status ? status_ff :
		sel_fault ? fault_word :
		sel_ctrl ? ctrl_word : gosfr_pkg::DATA_ZERO;

	// unmapped reads and idle cycles return zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_ff <= gosfr_pkg::DATA_ZERO;
		end else begin
			reg_rdata_ff <= reg_rd ? rd_mux : gosfr_pkg::DATA_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// pin one flag
	property p_pin_one;
		@(posedge core_clk) disable iff (rst)
		(cfg_one == gosfr_pkg::PIN_MODE_IN_HIGH) |=> status_ff[6] == $past(pin_one_in);
	endproperty
	a_pin_one: assert property (p_pin_one) else $error("pin one flag wrong");

	property p_pin_two;
		@(posedge core_clk) disable iff (rst)
		(cfg_two == gosfr_pkg::PIN_MODE_SPECIAL) |=> status_ff[5] == $past(pin_two_in);
	endproperty
	a_pin_two: assert property (p_pin_two) else $error("acc level flag wrong");

	property p_pin_three;
		@(posedge core_clk) disable iff (rst)
		(cfg_three == gosfr_pkg::PIN_MODE_IN_LOW) && !pin_three_in |=> status_ff[4];
	endproperty
	a_pin_three: assert property (p_pin_three) else $error("pin three flag wrong");

	property p_live;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> status_ff[3:2] == $past({adc_snapshot_busy, energy_overflow});
	endproperty
	a_live: assert property (p_live) else $error("status not live");

	property p_wake;
		@(posedge core_clk) disable iff (rst)
		stuck_bus_wake_evt && stuck_bus_wake_enable |=> fault_q[3];
	endproperty
	a_wake: assert property (p_wake) else $error("wake fault not set");

	property p_hold;
		@(posedge core_clk) disable iff (rst)
		fault_q[2] && !(wr_fault && !reg_wdata[2]) |=> fault_q[2];
	endproperty
	a_hold: assert property (p_hold) else $error("fault dropped");

	property p_clear;
		@(posedge core_clk) disable iff (rst)
		wr_ctrl && !reg_wdata[gosfr_pkg::CTRL_ALERT_GEN] && !alert_evt |=> !alert_generated_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("alert not cleared");

	property p_alert_drive;
		@(posedge core_clk) disable iff (rst)
		alert_evt && (cfg_three == gosfr_pkg::PIN_MODE_SPECIAL) ##1
		(cfg_three == gosfr_pkg::PIN_MODE_SPECIAL) |=> pin_three_oe_ff;
	endproperty
	a_alert_drive: assert property (p_alert_drive) else $error("alert not driven");

	property p_no_drive;
		@(posedge core_clk) disable iff (rst)
		cfg_three[1] |=> !pin_three_oe_ff;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("input pin driven");

	property p_gpo;
		@(posedge core_clk) disable iff (rst)
		(cfg_three == gosfr_pkg::PIN_MODE_OUTPUT) |=> pin_three_oe_ff == $past(pull_down_ff);
	endproperty
	a_gpo: assert property (p_gpo) else $error("output bit ignored");

	property p_rsvd;
		@(posedge core_clk) disable iff (rst)
		reg_rd && sel_ctrl |=> reg_rdata_ff[5:0] == 6'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

	property p_pin_one_low;
		@(posedge core_clk) disable iff (rst)
		(cfg_one == gosfr_pkg::PIN_MODE_IN_LOW) |=>
		status_ff[gosfr_pkg::STAT_PIN_ONE] == !$past(pin_one_in);
	endproperty
	a_pin_one_low: assert property (p_pin_one_low) else $error("pin one low flag wrong");

	property p_pin_two_pol;
		@(posedge core_clk) disable iff (rst)
		cfg_two[1] |=>
		status_ff[gosfr_pkg::STAT_PIN_TWO] == ($past(pin_two_in) == $past(cfg_two[0]));
	endproperty
	a_pin_two_pol: assert property (p_pin_two_pol) else $error("pin two activity wrong");

	property p_live_cnt;
		@(posedge core_clk) disable iff (rst)
		1'b1 |=> status_ff[gosfr_pkg::STAT_CHARGE_OVF] == $past(charge_overflow) &&
		status_ff[gosfr_pkg::STAT_TIME_OVF] == $past(time_overflow);
	endproperty
	a_live_cnt: assert property (p_live_cnt) else $error("counter status not live");

	property p_ovf_fault;
		@(posedge core_clk) disable iff (rst)
		energy_overflow || charge_overflow || time_overflow |=>
		(fault_q[gosfr_pkg::FAULT_ENERGY] || !$past(energy_overflow)) &&
		(fault_q[gosfr_pkg::FAULT_CHARGE] || !$past(charge_overflow)) &&
		(fault_q[gosfr_pkg::FAULT_TIME] || !$past(time_overflow));
	endproperty
	a_ovf_fault: assert property (p_ovf_fault) else $error("overflow lost");

	property p_pin_fault;
		@(posedge core_clk) disable iff (rst)
		cfg_two[1] && (pin_two_in == cfg_two[0]) |=> fault_q[gosfr_pkg::FAULT_PIN_TWO];
	endproperty
	a_pin_fault: assert property (p_pin_fault) else $error("pin fault not latched");

	property p_alert_set;
		@(posedge core_clk) disable iff (rst)
		alert_evt || (wr_ctrl && reg_wdata[gosfr_pkg::CTRL_ALERT_GEN]) |=> alert_generated_ff;
	endproperty
	a_alert_set: assert property (p_alert_set) else $error("alert bit not set");

	property p_release;
		@(posedge core_clk) disable iff (rst)
		(cfg_three == gosfr_pkg::PIN_MODE_SPECIAL) && !alert_generated_ff |=> !pin_three_oe_ff;
	endproperty
	a_release: assert property (p_release) else $error("alert pin not released");

	property p_fault_clear;
		@(posedge core_clk) disable iff (rst)
		wr_fault && !reg_wdata[gosfr_pkg::FAULT_WAKE] && !wake_fault |=>
		!fault_q[gosfr_pkg::FAULT_WAKE];
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

	property p_rd_idle;
		@(posedge core_clk) disable iff (rst)
		!reg_rd |=> reg_rdata_ff == gosfr_pkg::DATA_ZERO;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

endmodule

// ### gosfr_host_model.sv
// ----------------------------------------------------------------
// host side of the register port, one access at a time
// ----------------------------------------------------------------
module gosfr_host_model (
	input wire logic core_clk,	// system clock
	output logic [7:0] reg_addr,	// register offset
	output logic reg_wr,	// write strobe
	output logic reg_rd,	// read strobe
	output logic [7:0] reg_wdata,	// write data
	input wire logic [7:0] reg_rdata_ff	// read data
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// released lines never keep the last value, so stale data cannot pass
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// data is registered, so it is taken just after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata_ff;
	endtask
endmodule

// ### gosfr_regs_tb_top.sv
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
	$display("MISMATCH %0t got %h exp %h", $time, (got), (exp)); end end

module gosfr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_ff;
	logic [7:0] cfg = 8'h00;
	logic [2:0] plvl = 3'h7;
	logic [3:0] ovf = 4'h0;
	logic wake_en = 1'b0;
	logic wake_evt = 1'b0;
	logic alert_evt = 1'b0;
	logic pin_three_out_ff;
	logic pin_three_oe_ff;
	logic alert_generated_ff;
	wire pin_three_in;
	int mismatches = 0;
	int compares = 0;

	// open-drain wire: the pin reads low whenever the block pulls it
	assign pin_three_in = pin_three_oe_ff ? pin_three_out_ff : plvl[0];

	always #5 core_clk = ~core_clk;

	gosfr_host_model u_host (
		.core_clk(core_clk),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff)
	);

	gosfr_regs u_dut (
		.core_clk(core_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff),
		.pin_config_field(cfg),
		.pin_one_in(plvl[2]),
		.pin_two_in(plvl[1]),
		.pin_three_in(pin_three_in),
		.adc_snapshot_busy(ovf[3]),
		.energy_overflow(ovf[2]),
		.charge_overflow(ovf[1]),
		.time_overflow(ovf[0]),
		.stuck_bus_wake_enable(wake_en),
		.stuck_bus_wake_evt(wake_evt),
		.alert_evt(alert_evt),
		.pin_three_out_ff(pin_three_out_ff),
		.pin_three_oe_ff(pin_three_oe_ff),
		.alert_generated_ff(alert_generated_ff)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		`CHK(d, e)
	endtask

	task automatic test_done();
		if (mismatches == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// pin two idles high as the acc input, so its state bit reads one
	task automatic t_reset();
		rd_chk(8'h40, 8'h20);
		rd_chk(8'h41, 8'h80);
		rd_chk(8'h42, 8'h00);
		rd_chk(8'h43, 8'h00);
		u_host.wr(8'h40, 8'hFF);
		u_host.wr(8'h42, 8'h3F);
		rd_chk(8'h40, 8'h20);
		rd_chk(8'h42, 8'h00);
	endtask

	// one source at a time: busy has no fault cell behind it
	task automatic t_ovf();
		for (int b = 0; b < 4; b++) begin
			@(posedge core_clk);
			ovf <= 4'h1 << b;
			cyc(3);
			rd_chk(8'h40, 8'h20 | (8'h01 << b));
			@(posedge core_clk);
			ovf <= 4'h0;
			cyc(3);
			rd_chk(8'h40, 8'h20);
			rd_chk(8'h41, (b == 3) ? 8'h80 : (8'h80 | (8'h01 << b)));
			u_host.wr(8'h41, 8'hFF);
			rd_chk(8'h41, (b == 3) ? 8'h80 : (8'h80 | (8'h01 << b)));
			u_host.wr(8'h41, 8'h00);
			rd_chk(8'h41, 8'h80);
		end
	endtask

	// both input polarities at both levels, all three pins together
	task automatic t_pins();
		logic act;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			cfg <= {{3{i[1] ? 2'h3 : 2'h2}}, 2'h0};
			plvl <= {3{i[0]}};
			cyc(3);
			u_host.wr(8'h41, 8'h00);
			cyc(1);
			act = i[1] ~^ i[0];
			rd_chk(8'h40, {1'b0, {3{act}}, 4'h0});
			rd_chk(8'h41, {1'b1, {3{act}}, 4'h0});
		end
		@(posedge core_clk);
		cfg <= 8'h00;
		plvl <= 3'h7;
		cyc(3);
		rd_chk(8'h40, 8'h20);
		u_host.wr(8'h41, 8'h00);
		rd_chk(8'h41, 8'h80);
	endtask

	task automatic t_wake();
		for (int e = 0; e < 2; e++) begin
			@(posedge core_clk);
			wake_en <= e[0];
			wake_evt <= 1'b1;
			@(posedge core_clk);
			wake_evt <= 1'b0;
			cyc(2);
			rd_chk(8'h41, {1'b1, 3'h0, e[0], 3'h0});
		end
		u_host.wr(8'h41, 8'h00);
		rd_chk(8'h41, 8'h80);
	endtask

	task automatic t_alert();
		@(posedge core_clk);
		alert_evt <= 1'b1;
		@(posedge core_clk);
		alert_evt <= 1'b0;
		cyc(2);
		`CHK(alert_generated_ff, 1'b1)
		`CHK(pin_three_oe_ff, 1'b1)
		`CHK(pin_three_out_ff, 1'b0)
		rd_chk(8'h42, 8'h80);
		u_host.wr(8'h42, 8'h00);
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b0)
		u_host.wr(8'h42, 8'h80);
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b1)
		@(posedge core_clk);
		cfg <= 8'h0C;
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b0)
		u_host.wr(8'h42, 8'h40);
		@(posedge core_clk);
		cfg <= 8'h04;
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b1)
		rd_chk(8'h42, 8'h40);
		for (int m = 0; m < 4; m += 2) begin
			@(posedge core_clk);
			cfg <= {4'h0, m[1:0] + 2'h2, 2'h0};
			cyc(2);
			`CHK(pin_three_oe_ff, 1'b0)
		end
		@(posedge core_clk);
		cfg <= 8'h04;
		u_host.wr(8'h42, 8'h00);
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b0)
	endtask

	// output modes read zero; a mid-run reset drops every latch
	task automatic t_rst_mid();
		@(posedge core_clk);
		cfg <= 8'h54;
		cyc(2);
		rd_chk(8'h40, 8'h00);
		u_host.wr(8'h42, 8'hC0);
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b1)
		@(posedge core_clk);
		ovf <= 4'h7;
		@(posedge core_clk);
		ovf <= 4'h0;
		rst <= 1'b1;
		cyc(2);
		`CHK(pin_three_oe_ff, 1'b0)
		`CHK(alert_generated_ff, 1'b0)
		@(posedge core_clk);
		rst <= 1'b0;
		rd_chk(8'h41, 8'h80);
		rd_chk(8'h42, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_ovf();
		t_pins();
		t_wake();
		t_alert();
		t_rst_mid();
		test_done();
	end

	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		test_done();
	end
endmodule
